// ---- verilog/lpt_timing_regs.sv ----
// APB register slice and test pattern timing for two output channels
//
// Summary of operation
// - Channel B frame sync width upper bits used only in independent grouping.
// - Channel A line back porch shared by B unless grouping is independent.
// - Channel B line back porch honoured only in independent grouping.
// - Channel A frame back porch, lines, used only by the test pattern.
// - Channel B frame back porch used only for pattern, independent grouping only.
// - Channel A line front porch, pixels, used only by the test pattern.
// - Channel B line front porch used only for pattern, independent grouping.
// - Pattern enable per channel runs a pattern with that channel's timing; channel B runs only in independent grouping.
// - Frame sync widths are ten bits: low register plus upper register bits; line sync width is one byte.
`timescale 1ns/1ps
`default_nettype none
`include "lpt_consts.svh"
module lpt_timing_regs
    import lpt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic first_out_hsync,
    output logic first_out_vsync,
    output logic first_out_de,
    output logic second_out_hsync,
    output logic second_out_vsync,
    output logic second_out_de,
    output logic [9:0] second_out_vert_sync_width,
    output logic [7:0] second_out_line_back_porch_eff
);
    logic [7:0] b_vsw_up_r, a_hbp_r, b_hbp_r, a_vbp_r, b_vbp_r, a_hfp_r, b_hfp_r;
    logic [7:0] a_vsw_lo_r, b_vsw_lo_r, a_vsw_up_r, sync_w_r, act_r, cfg_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic ah_r, av_r, ad_r, bh_r, bv_r, bd_r;
    logic [9:0] bvsw_r;
    logic [7:0] bhbp_r;

    function automatic logic [11:0] idx_addr(input logic [7:0] idx);
        idx_addr = {2'b00, idx, 2'b00};
    endfunction

    wire access = psel && penable && !pready_r;
    wire wr = psel && penable && pready_r && pwrite && pstrb[0]; // Lands with the answer
    wire [7:0] wb = pwdata[7:0];
    wire hit_b_vsw_up = paddr == idx_addr(`LPT_IDX_B_VSW_UP);
    wire hit_a_hbp = paddr == idx_addr(`LPT_IDX_A_HBP);
    wire hit_b_hbp = paddr == idx_addr(`LPT_IDX_B_HBP);
    wire hit_a_vbp = paddr == idx_addr(`LPT_IDX_A_VBP);
    wire hit_b_vbp = paddr == idx_addr(`LPT_IDX_B_VBP);
    wire hit_a_hfp = paddr == idx_addr(`LPT_IDX_A_HFP);
    wire hit_b_hfp = paddr == idx_addr(`LPT_IDX_B_HFP);
    wire hit_a_vsw_lo = paddr == idx_addr(`LPT_IDX_A_VSW_LO);
    wire hit_b_vsw_lo = paddr == idx_addr(`LPT_IDX_B_VSW_LO);
    wire hit_a_vsw_up = paddr == idx_addr(`LPT_IDX_A_VSW_UP);
    wire hit_sync_w = paddr == idx_addr(`LPT_IDX_SYNC_W);
    wire hit_act = paddr == idx_addr(`LPT_IDX_ACT);
    wire hit_cfg = paddr == idx_addr(`LPT_IDX_CFG);
    wire hit_stat = paddr == idx_addr(`LPT_IDX_STAT);
    wire hit_any = hit_b_vsw_up | hit_a_hbp | hit_b_hbp | hit_a_vbp | hit_b_vbp
        | hit_a_hfp | hit_b_hfp | hit_a_vsw_lo | hit_b_vsw_lo | hit_a_vsw_up
        | hit_sync_w | hit_act | hit_cfg | hit_stat;

    // Mode decode
    wire indep = cfg_r[`LPT_CFG_GRP_MSB:`LPT_CFG_GRP_LSB] == `LPT_GRP_INDEP;
    wire en_a = cfg_r[`LPT_CFG_ENA_BIT];
    wire en_b = cfg_r[`LPT_CFG_ENB_BIT];
    wire ph_a_h, ph_a_v, ph_a_d, ph_b_h, ph_b_v, ph_b_d;

    // Ten-bit frame sync widths from low and upper registers; line sync width and active length zero-extended
    wire [9:0] a_vsw = {a_vsw_up_r[1:0], a_vsw_lo_r};
    wire [9:0] b_vsw_own = {b_vsw_up_r[1:0], b_vsw_lo_r};
    wire [9:0] hsw = {2'b00, sync_w_r};
    wire [9:0] act_len = {2'b00, act_r};

    // Channel B falls back to channel A values unless grouping is independent
    wire [9:0] b_vsw = indep ? b_vsw_own : a_vsw;
    wire [7:0] b_hbp = indep ? b_hbp_r : a_hbp_r;
    wire [7:0] b_vbp = indep ? b_vbp_r : a_vbp_r;
    wire [7:0] b_hfp = indep ? b_hfp_r : a_hfp_r;
    wire b_run = en_b && indep;

    wire [31:0] rd_mux =
        hit_b_vsw_up ? {24'h000000, b_vsw_up_r} :
        hit_a_hbp ? {24'h000000, a_hbp_r} :
        hit_b_hbp ? {24'h000000, b_hbp_r} :
        hit_a_vbp ? {24'h000000, a_vbp_r} :
        hit_b_vbp ? {24'h000000, b_vbp_r} :
        hit_a_hfp ? {24'h000000, a_hfp_r} :
        hit_b_hfp ? {24'h000000, b_hfp_r} :
        hit_a_vsw_lo ? {24'h000000, a_vsw_lo_r} :
        hit_b_vsw_lo ? {24'h000000, b_vsw_lo_r} :
        hit_a_vsw_up ? {24'h000000, a_vsw_up_r} :
        hit_sync_w ? {24'h000000, sync_w_r} :
        hit_act ? {24'h000000, act_r} :
        hit_cfg ? {24'h000000, cfg_r} :
        hit_stat ? {26'h0000000, ph_b_d, ph_b_v, ph_b_h, ph_a_d, ph_a_v, ph_a_h} :
        32'h00000000;

    // APB slave: one wait state, error on unmapped address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= access;
            pslverr_r <= access && !hit_any;
            prdata_r <= (access && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Writable registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            b_vsw_up_r <= `LPT_RST_BYTE;
            a_hbp_r <= `LPT_RST_BYTE;
            b_hbp_r <= `LPT_RST_BYTE;
            a_vbp_r <= `LPT_RST_BYTE;
            b_vbp_r <= `LPT_RST_BYTE;
            a_hfp_r <= `LPT_RST_BYTE;
            b_hfp_r <= `LPT_RST_BYTE;
            a_vsw_lo_r <= `LPT_RST_BYTE;
            b_vsw_lo_r <= `LPT_RST_BYTE;
            a_vsw_up_r <= `LPT_RST_BYTE;
            sync_w_r <= `LPT_RST_SYNC_W;
            act_r <= `LPT_RST_ACT;
            cfg_r <= `LPT_RST_BYTE;
        end else if (wr) begin
            if (hit_b_vsw_up) b_vsw_up_r <= wb & `LPT_UP_MASK;
            if (hit_a_hbp) a_hbp_r <= wb;
            if (hit_b_hbp) b_hbp_r <= wb;
            if (hit_a_vbp) a_vbp_r <= wb;
            if (hit_b_vbp) b_vbp_r <= wb;
            if (hit_a_hfp) a_hfp_r <= wb;
            if (hit_b_hfp) b_hfp_r <= wb;
            if (hit_a_vsw_lo) a_vsw_lo_r <= wb;
            if (hit_b_vsw_lo) b_vsw_lo_r <= wb;
            if (hit_a_vsw_up) a_vsw_up_r <= wb & `LPT_UP_MASK;
            if (hit_sync_w) sync_w_r <= wb;
            if (hit_act) act_r <= wb;
            if (hit_cfg) cfg_r <= wb;
        end
    end

    lpt_pattern_gen #(.CW(10)) u_gen_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(en_a),
        .h_sync(hsw),
        .h_back(a_hbp_r),
        .h_act(act_len),
        .h_front(a_hfp_r),
        .v_sync(a_vsw),
        .v_back(a_vbp_r),
        .v_act(act_len),
        .v_front(a_hfp_r),
        .hsync(ph_a_h),
        .vsync(ph_a_v),
        .de(ph_a_d),
        .h_phase(),
        .v_phase()
    );

    lpt_pattern_gen #(.CW(10)) u_gen_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(b_run),
        .h_sync(hsw),
        .h_back(b_hbp),
        .h_act(act_len),
        .h_front(b_hfp),
        .v_sync(b_vsw),
        .v_back(b_vbp),
        .v_act(act_len),
        .v_front(b_hfp),
        .hsync(ph_b_h),
        .vsync(ph_b_v),
        .de(ph_b_d),
        .h_phase(),
        .v_phase()
    );

    // Register the outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {ah_r, av_r, ad_r, bh_r, bv_r, bd_r} <= 6'h00;
            bvsw_r <= 10'h000;
            bhbp_r <= 8'h00;
        end else begin
            {ah_r, av_r, ad_r, bh_r, bv_r, bd_r} <= {ph_a_h, ph_a_v, ph_a_d, ph_b_h, ph_b_v, ph_b_d};
            bvsw_r <= b_vsw;
            bhbp_r <= b_hbp;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign first_out_hsync = ah_r;
    assign first_out_vsync = av_r;
    assign first_out_de = ad_r;
    assign second_out_hsync = bh_r;
    assign second_out_vsync = bv_r;
    assign second_out_de = bd_r;
    assign second_out_vert_sync_width = bvsw_r;
    assign second_out_line_back_porch_eff = bhbp_r;

    a_upper_mask: assert property (@(posedge clk) disable iff (sys_rst)
        b_vsw_up_r[7:4] == 4'h0) else $error("upper sync register reserved bits set");
    a_b_width_indep: assert property (@(posedge clk) disable iff (sys_rst)
        indep |=> bvsw_r == {$past(b_vsw_up_r[1:0]), $past(b_vsw_lo_r)})
        else $error("channel B sync width not formed from its registers");
    a_b_hbp_shared: assert property (@(posedge clk) disable iff (sys_rst)
        !indep |=> bhbp_r == $past(a_hbp_r)) else $error("channel B not sharing back porch");
    a_b_hbp_own: assert property (@(posedge clk) disable iff (sys_rst)
        indep |=> bhbp_r == $past(b_hbp_r)) else $error("channel B own back porch ignored");
    a_b_gated: assert property (@(posedge clk) disable iff (sys_rst)
        !b_run |=> !bd_r && !bh_r) else $error("channel B pattern without enable");
    a_a_gated: assert property (@(posedge clk) disable iff (sys_rst)
        !en_a |=> !ad_r && !ah_r) else $error("channel A pattern without enable");
    a_write_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_a_vbp |=> a_vbp_r == $past(wb)) else $error("frame back porch write lost");
    a_hfp_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_a_hfp |=> a_hfp_r == $past(wb)) else $error("front porch write lost");
    a_b_vbp_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_b_vbp |=> b_vbp_r == $past(wb)) else $error("B frame back porch write lost");
    a_b_hfp_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_b_hfp |=> b_hfp_r == $past(wb)) else $error("B front porch write lost");
    a_apb_ready: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable && !pready |=> pready) else $error("APB access not answered");

    // Handshake steps of one access
    sequence s_apb_taken;
        psel && penable && !pready;
    endsequence
    sequence s_apb_answer;
        pready ##1 !pready;
    endsequence
    a_ready_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        s_apb_taken |=> s_apb_answer)
        else $error("APB answer not a single cycle");

    // Register stores
    a_b_upper_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_b_vsw_up |=> b_vsw_up_r == ($past(wb) & `LPT_UP_MASK))
        else $error("channel B upper sync write lost");
    a_a_upper_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_a_vsw_up |=> a_vsw_up_r == ($past(wb) & `LPT_UP_MASK))
        else $error("channel A upper sync write lost");
    a_b_low_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_b_vsw_lo |=> b_vsw_lo_r == $past(wb))
        else $error("channel B low sync write lost");
    a_a_hbp_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_a_hbp |=> a_hbp_r == $past(wb))
        else $error("channel A back porch write lost");
    a_b_hbp_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr && hit_b_hbp |=> b_hbp_r == $past(wb))
        else $error("channel B back porch write lost");

    // Channel B selection
    a_b_width_shared: assert property (@(posedge clk) disable iff (sys_rst)
        !indep |=> bvsw_r == {$past(a_vsw_up_r[1:0]), $past(a_vsw_lo_r)})
        else $error("channel B sync width not shared");
    a_b_vbp_shared: assert property (@(posedge clk) disable iff (sys_rst)
        !indep |-> b_vbp == a_vbp_r)
        else $error("channel B not sharing frame back porch");
    a_b_vbp_own: assert property (@(posedge clk) disable iff (sys_rst)
        indep |-> b_vbp == b_vbp_r)
        else $error("channel B own frame back porch ignored");
    a_b_hfp_shared: assert property (@(posedge clk) disable iff (sys_rst)
        !indep |-> b_hfp == a_hfp_r)
        else $error("channel B not sharing front porch");
    a_b_hfp_own: assert property (@(posedge clk) disable iff (sys_rst)
        indep |-> b_hfp == b_hfp_r)
        else $error("channel B own front porch ignored");

    // Pattern enable and phase order
    a_a_vs_gated: assert property (@(posedge clk) disable iff (sys_rst)
        !en_a |=> !av_r)
        else $error("channel A frame sync without enable");
    a_b_vs_gated: assert property (@(posedge clk) disable iff (sys_rst)
        !b_run |=> !bv_r)
        else $error("channel B frame sync without enable");
    a_a_start: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(en_a) |=> ah_r && av_r && !ad_r)
        else $error("channel A pattern not starting in sync");
    a_b_start: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(b_run) |=> bh_r && bv_r && !bd_r)
        else $error("channel B pattern not starting in sync");
    a_a_de_excl: assert property (@(posedge clk) disable iff (sys_rst)
        ad_r |-> !ah_r && !av_r)
        else $error("channel A active during sync");
    a_b_de_excl: assert property (@(posedge clk) disable iff (sys_rst)
        bd_r |-> !bh_r && !bv_r)
        else $error("channel B active during sync");
endmodule
`default_nettype wire

// ---- verilog/lpt_consts.svh ----
// Register offsets, field layouts and reset values of the porch timing block
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH
`define LPT_IDX_B_VSW_UP 8'h33
`define LPT_IDX_A_HBP 8'h34
`define LPT_IDX_B_HBP 8'h35
`define LPT_IDX_A_VBP 8'h36
`define LPT_IDX_B_VBP 8'h37
`define LPT_IDX_A_HFP 8'h38
`define LPT_IDX_B_HFP 8'h39
`define LPT_IDX_A_VSW_LO 8'h40
`define LPT_IDX_B_VSW_LO 8'h41
`define LPT_IDX_A_VSW_UP 8'h42
`define LPT_IDX_SYNC_W 8'h43
`define LPT_IDX_ACT 8'h44
`define LPT_IDX_CFG 8'h45
`define LPT_IDX_STAT 8'h46
`define LPT_UP_MSB 3
`define LPT_UP_MASK 8'h0F
`define LPT_CFG_ENA_BIT 4
`define LPT_CFG_ENB_BIT 0
`define LPT_CFG_GRP_LSB 5
`define LPT_CFG_GRP_MSB 6
`define LPT_CFG_SINGLE_BIT 7
`define LPT_GRP_INDEP 2'h2
`define LPT_RST_BYTE 8'h00
`define LPT_RST_SYNC_W 8'h04
`define LPT_RST_ACT 8'h10
`endif

// ---- verilog/lpt_pkg.sv ----
// Types shared by the porch timing block
package lpt_pkg;
    typedef enum logic [1:0] {
        LPT_SYNC = 2'b00,
        LPT_BACK = 2'b01,
        LPT_ACTIVE = 2'b10,
        LPT_FRONT = 2'b11
    } lpt_phase_e;
    typedef logic [9:0] lpt_width_t;
endpackage

// ---- verilog/lpt_pattern_gen.sv ----
// Test pattern timing generator for one output channel
`timescale 1ns/1ps
`default_nettype none
module lpt_pattern_gen
    import lpt_pkg::*;
#(
    parameter int CW = 10
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [CW-1:0] h_sync,
    input wire logic [7:0] h_back,
    input wire logic [CW-1:0] h_act,
    input wire logic [7:0] h_front,
    input wire logic [CW-1:0] v_sync,
    input wire logic [7:0] v_back,
    input wire logic [CW-1:0] v_act,
    input wire logic [7:0] v_front,
    output logic hsync,
    output logic vsync,
    output logic de,
    output var lpt_phase_e h_phase,
    output var lpt_phase_e v_phase
);
    logic [CW-1:0] hcnt_r;
    logic [CW-1:0] vcnt_r;
    logic [CW-1:0] h_len;
    logic [CW-1:0] v_len;
    wire h_done;
    wire v_done;
    lpt_phase_e h_phase_r;
    lpt_phase_e v_phase_r;

    // Length of the current phase; zero counts as one cycle
    always_comb begin
        case (h_phase_r)
            LPT_SYNC: h_len = h_sync;
            LPT_BACK: h_len = CW'(h_back);
            LPT_ACTIVE: h_len = h_act;
            LPT_FRONT: h_len = CW'(h_front);
            default: h_len = '0;
        endcase
        case (v_phase_r)
            LPT_SYNC: v_len = v_sync;
            LPT_BACK: v_len = CW'(v_back);
            LPT_ACTIVE: v_len = v_act;
            LPT_FRONT: v_len = CW'(v_front);
            default: v_len = '0;
        endcase
    end
    assign h_done = (hcnt_r + CW'(1)) >= h_len;
    assign v_done = (vcnt_r + CW'(1)) >= v_len;

    // Line and frame sequence: sync, back porch, active, front porch
    always_ff @(posedge clk) begin
        if (sys_rst || !enable) begin
            hcnt_r <= '0;
            vcnt_r <= '0;
            h_phase_r <= LPT_SYNC;
            v_phase_r <= LPT_SYNC;
        end else if (h_done) begin
            hcnt_r <= '0;
            h_phase_r <= lpt_phase_e'(h_phase_r + 2'h1);
            if (h_phase_r == LPT_FRONT) begin
                if (v_done) begin
                    vcnt_r <= '0;
                    v_phase_r <= lpt_phase_e'(v_phase_r + 2'h1);
                end else begin
                    vcnt_r <= vcnt_r + CW'(1);
                end
            end
        end else begin
            hcnt_r <= hcnt_r + CW'(1);
        end
    end

    assign hsync = enable && h_phase_r == LPT_SYNC;
    assign vsync = enable && v_phase_r == LPT_SYNC;
    assign de = enable && h_phase_r == LPT_ACTIVE && v_phase_r == LPT_ACTIVE;
    assign h_phase = h_phase_r;
    assign v_phase = v_phase_r;
endmodule
`default_nettype wire

// ---- dv/lpt_tb.sv ----
// Self-checking testbench for the porch timing register slice
`timescale 1ns/1ps
`default_nettype none
`include "lpt_consts.svh"
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire a_hs;
    wire a_vs;
    wire a_de;
    wire b_hs;
    wire b_vs;
    wire b_de;
    wire [9:0] b_vsw;
    wire [7:0] b_hbp;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    lpt_timing_regs i_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .first_out_hsync(a_hs),
        .first_out_vsync(a_vs),
        .first_out_de(a_de),
        .second_out_hsync(b_hs),
        .second_out_vsync(b_vs),
        .second_out_de(b_de),
        .second_out_vert_sync_width(b_vsw),
        .second_out_line_back_porch_eff(b_hbp)
    );

    task automatic final_report;
        $display("checks %0d errors %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report;
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer: setup, access, hold until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [3:0] sb, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        pstrb <= sb;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            $display("ERROR pready expected 1 seen %b", pready);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, 4'hF, r, e);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic ee, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0000_0000, 4'hF, r, e);
        chk(nm, exp, r);
        chk(nm, {31'h0, ee}, {31'h0, e});
    endtask

    function automatic logic hs(input bit ch);
        return ch ? b_hs : a_hs;
    endfunction

    // Line period and sync width, rising edge to rising edge
    task automatic meas(input bit ch, output int per, output int hw);
        int n;
        per = 0;
        hw = 0;
        n = 0;
        while (hs(ch) !== 1'b0 && n < 400) begin @(posedge clk); n++; end
        while (hs(ch) !== 1'b1 && n < 400) begin @(posedge clk); n++; end
        while (hs(ch) === 1'b1 && n < 400) begin @(posedge clk); n++; per++; hw++; end
        while (hs(ch) !== 1'b1 && n < 400) begin @(posedge clk); n++; per++; end
    endtask

    // Frame period, frame sync width and active cycles of channel A
    task automatic frame(output int per, output int vw, output int dc);
        int n;
        per = 0;
        vw = 0;
        dc = 0;
        n = 0;
        while (a_vs !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        while (a_vs !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        while (a_vs === 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
            per++;
            vw++;
        end
        while (a_vs !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
            per++;
            dc += (a_de === 1'b1) ? 1 : 0;
        end
    endtask

    initial begin
        int i;
        int per;
        int hw;
        int dc;
        int hb[2];
        int hf[2];
        logic [31:0] r;
        logic e;
        hb = '{0, 9};
        hf = '{7, 0};
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            rd(8'(8'h33 + i), 32'h0000_0000, 1'b0, "reset_value");
        end
        for (i = 0; i < 7; i++) begin
            wr(8'(8'h33 + i), 32'(32'hFFFF_FFA1 + i));
        end
        for (i = 0; i < 7; i++) begin
            rd(8'(8'h33 + i), (i == 0) ? 32'h01 : 32'(32'hA1 + i), 1'b0, "readback");
        end
        apb(1'b1, `LPT_IDX_A_HBP, 32'h0000_0077, 4'hE, r, e);
        rd(`LPT_IDX_A_HBP, 32'h0000_00A2, 1'b0, "strobe_off");
        apb(1'b1, 8'h20, 32'h0000_0055, 4'hF, r, e);
        chk("unmapped_wr_err", 32'h1, {31'h0, e});
        rd(8'h20, 32'h0000_0000, 1'b1, "unmapped_rd");
        wr(`LPT_IDX_B_VSW_LO, 32'h5A);
        wr(`LPT_IDX_B_VSW_UP, 32'h0F);
        wr(`LPT_IDX_A_VSW_LO, 32'hC3);
        wr(`LPT_IDX_A_VSW_UP, 32'h01);
        rd(`LPT_IDX_B_VSW_UP, 32'h0000_000F, 1'b0, "upper_keep");
        wr(`LPT_IDX_CFG, 32'h40);
        repeat (3) @(posedge clk);
        chk("b_vsw_indep", 32'h35A, {22'h0, b_vsw});
        chk("b_hbp_indep", 32'hA3, {24'h0, b_hbp});
        wr(`LPT_IDX_CFG, 32'h20);
        repeat (3) @(posedge clk);
        chk("b_vsw_shared", 32'h1C3, {22'h0, b_vsw});
        chk("b_hbp_shared", 32'hA2, {24'h0, b_hbp});
        for (i = 0; i < 2; i++) begin
            wr(`LPT_IDX_CFG, 32'h00);
            wr(`LPT_IDX_A_HBP, 32'(hb[i]));
            wr(`LPT_IDX_A_HFP, 32'(hf[i]));
            wr(`LPT_IDX_CFG, 32'h10);
            meas(1'b0, per, hw);
            chk("a_line", 32'(4 + (hb[i] ? hb[i] : 1) + 16 + (hf[i] ? hf[i] : 1)), per);
            chk("a_sync", 32'h4, hw);
        end
        wr(`LPT_IDX_CFG, 32'h00);
        wr(`LPT_IDX_B_HBP, 32'h02);
        wr(`LPT_IDX_B_HFP, 32'h03);
        wr(`LPT_IDX_CFG, 32'h51);
        meas(1'b1, per, hw);
        chk("b_line", 32'h19, per);
        chk("b_sync", 32'h4, hw);
        wr(`LPT_IDX_CFG, 32'h11);
        repeat (3) @(posedge clk);
        hw = 0;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            hw += (b_hs !== 1'b0 || b_vs !== 1'b0 || b_de !== 1'b0) ? 1 : 0;
        end
        chk("b_idle_shared", 32'h0, hw);
        wr(`LPT_IDX_CFG, 32'h00);
        wr(`LPT_IDX_A_VSW_LO, 32'h01);
        wr(`LPT_IDX_A_VSW_UP, 32'h00);
        wr(`LPT_IDX_A_VBP, 32'h02);
        wr(`LPT_IDX_A_HBP, 32'h03);
        wr(`LPT_IDX_A_HFP, 32'h05);
        wr(`LPT_IDX_CFG, 32'h10);
        frame(per, hw, dc);
        chk("a_frame", 32'h2A0, per);
        chk("a_vsync", 32'h1C, hw);
        chk("a_de", 32'h100, dc);
        final_report;
    end
endmodule
`default_nettype wire
